// ===== src/dmg_pkg.sv
// dmg_pkg: register map, field positions, reset values and sizes for the
// demagnetization event generator.
// assumes: a single 50 MHz clock domain; used as dmg_pkg::name everywhere.
package dmg_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_MASK = 4'h2;
   localparam logic [3:0] ADDR_DTIME = 4'h3;
   localparam logic [3:0] ADDR_TIMER = 4'h4;
   // control register fields
   localparam int CTRL_HW_CAP_BIT = 0;
   localparam int CTRL_SIM_BIT = 1;
   localparam int CTRL_HALL_BIT = 2;
   localparam int CTRL_EDGE_BIT = 3;
   localparam int CTRL_FILT_LSB = 4;
   localparam int FILT_W = 3;
   // status / mask fields
   localparam int STAT_DEMAG_BIT = 0;
   // data widths
   localparam int DATA_W = 8;
   localparam int TIMER_W = 8;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] DTIME_RST = 8'hff;
endpackage : dmg_pkg

// ===== src/dmg_filter.sv
// dmg_filter: counts consecutive qualifying samples of the selected sense
// input and fires once when one more than the programmed count is reached.
// assumes: sample input is already synchronised to clock_in.
`timescale 1ns/1ps
module dmg_filter (
   // clock and reset
   input wire logic clock_in,
   input wire logic srst_in,
   // control
   input wire logic arm_in,
   input wire logic [dmg_pkg::FILT_W-1:0] need_in,
   input wire logic qual_in,
   // result
   output logic hit_out
);
   logic [dmg_pkg::FILT_W:0] cnt_q;
   logic [dmg_pkg::FILT_W:0] cnt_d;
   wire [dmg_pkg::FILT_W:0] target = {1'b0, need_in} + 4'h1;

   // a run of qualifying samples resets on any miss
   always_comb begin
      cnt_d = cnt_q;
      if (!arm_in || !qual_in) begin
         cnt_d = '0;
      end else if (cnt_q != target) begin
         cnt_d = cnt_q + 4'h1;
      end
   end

   assign hit_out = arm_in && qual_in && (cnt_q + 4'h1 == target);

   // counter
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   a_filter_run: assert property (
      @(posedge clock_in) disable iff (srst_in)
      hit_out |-> $past(qual_in) || need_in == 3'h0)
      else $error("filter fired without a run of samples");
endmodule : dmg_filter

// ===== src/dmg_event_gen.sv
// dmg_event_gen: demagnetization event generator with register port,
// sticky status, mask and level interrupt.
// assumes: rotor sense input is asynchronous; commutation pulse and step
// timer come from same-clock logic; software clears status by writing one.
`timescale 1ns/1ps
// Overview of operation
// - hardware event is an edge on the selected rotor sense input
// - filter requires one more than the programmed count of consecutive qualifying samples
// - with capture on, hardware event copies step timer into demag time
// - with simulation on, timer equal to demag time gives simulated event
// - with both sources on, the first one gives the only event
// - capture off, simulation on: simulated event masks until zero crossing
// - either event sets demag flag; interrupt only when mask bit set
// - after commutation with simulation on, demag time at or below timer fires at once
// - forced immediate event overwrites demag time with step timer
// - hall sensor mode disables demagnetization events and filters
module dmg_event_gen (
   // clock and reset
   input wire logic clock_in,
   input wire logic srst_in,
   // register port
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // motor side
   input wire logic rotor_sense_input_in,
   input wire logic commutate_in,
   input wire logic [7:0] step_timer_in,
   // results
   output logic demag_event_out,
   output logic irq_out
);
   logic [7:0] ctrl_q;
   logic [7:0] mask_q;
   logic [7:0] dtime_q;
   logic [7:0] dtime_d;
   logic demag_flag_q;
   logic [7:0] rdata_q;
   logic irq_q;
   logic event_q;
   logic armed_q;
   logic check_q;
   logic s1_q, s2_q, s3_q;
   logic level_q;
   logic prev_q;
   logic hw_hit;

   // control decode
   wire hw_demag_capture_en = ctrl_q[dmg_pkg::CTRL_HW_CAP_BIT];
   wire sim_demag_en = ctrl_q[dmg_pkg::CTRL_SIM_BIT];
   wire hall_sensor_select = ctrl_q[dmg_pkg::CTRL_HALL_BIT];
   wire edge_rise = ctrl_q[dmg_pkg::CTRL_EDGE_BIT];
   wire [2:0] demag_count_filter =
      ctrl_q[dmg_pkg::CTRL_FILT_LSB +: dmg_pkg::FILT_W];
   wire demag_irq_mask = mask_q[dmg_pkg::STAT_DEMAG_BIT];

   // register strobes
   wire wr_ctrl = wr_in && addr_in == dmg_pkg::ADDR_CTRL;
   wire wr_stat = wr_in && addr_in == dmg_pkg::ADDR_STATUS;
   wire wr_mask = wr_in && addr_in == dmg_pkg::ADDR_MASK;
   wire wr_dtime = wr_in && addr_in == dmg_pkg::ADDR_DTIME;

   // demag logic works only outside hall sensor mode
   wire feature_on = !hall_sensor_select;
   wire live = feature_on && armed_q;

   // qualified sense: settled level differs from the level before commute
   wire sense_stable = (s2_q == s3_q);
   wire qual = sense_stable && (s3_q == edge_rise) &&
      (prev_q != edge_rise);

   dmg_filter u_filter (
      .clock_in(clock_in),
      .srst_in(srst_in),
      .arm_in(live),
      .need_in(demag_count_filter),
      .qual_in(qual),
      .hit_out(hw_hit)
   );

   // simulated sources: plain compare and the post-commute check
   wire sim_match = live && sim_demag_en &&
      step_timer_in == dtime_q;
   wire sim_force = check_q && feature_on && sim_demag_en &&
      dtime_q <= step_timer_in;
   // capture off with simulation on: the pin edge must not end the mask
   wire hw_src_on = hw_demag_capture_en || !sim_demag_en;
   wire hw_event = hw_hit && hw_src_on && !sim_match && !sim_force;
   // one merged event: first arrival wins, later ones see armed low
   wire demag_now = (hw_hit && hw_src_on) || sim_match ||
      sim_force;

   // demag time: capture, forced overwrite, else software write
   always_comb begin
      dtime_d = dtime_q;
      if (wr_dtime) begin
         dtime_d = wdata_in;
      end
      if (hw_event && hw_demag_capture_en) begin
         dtime_d = step_timer_in;
      end
      if (sim_force) begin
         dtime_d = step_timer_in;
      end
   end

   wire [7:0] rd_mux =
      addr_in == dmg_pkg::ADDR_CTRL ? ctrl_q :
      addr_in == dmg_pkg::ADDR_STATUS ? {7'h00, demag_flag_q} :
      addr_in == dmg_pkg::ADDR_MASK ? mask_q :
      addr_in == dmg_pkg::ADDR_DTIME ? dtime_q :
      addr_in == dmg_pkg::ADDR_TIMER ? step_timer_in : 8'h00;

   // set wins over a clear in the same cycle
   wire flag_d = demag_now ||
      (demag_flag_q && !(wr_stat && wdata_in[dmg_pkg::STAT_DEMAG_BIT]));

   // three-stage sync of the asynchronous sense pin
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= rotor_sense_input_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (sense_stable) begin
            level_q <= s3_q;
         end
      end
   end

   // step sequencing: arm on commutation, disarm on the event
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         armed_q <= 1'b0;
         check_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         check_q <= commutate_in;
         if (commutate_in) begin
            armed_q <= 1'b1;
            prev_q <= level_q;
         end else if (demag_now) begin
            armed_q <= 1'b0;
         end
      end
   end

   // registers
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ctrl_q <= dmg_pkg::CTRL_RST;
         mask_q <= dmg_pkg::MASK_RST;
         dtime_q <= dmg_pkg::DTIME_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wdata_in;
         end
         if (wr_mask) begin
            mask_q <= {7'h00, wdata_in[dmg_pkg::STAT_DEMAG_BIT]};
         end
         dtime_q <= dtime_d;
      end
   end

   // status, interrupt, event and read data
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         demag_flag_q <= 1'b0;
         irq_q <= 1'b0;
         event_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         demag_flag_q <= flag_d;
         irq_q <= flag_d && demag_irq_mask;
         event_q <= demag_now;
         rdata_q <= rd_in ? rd_mux : 8'h00;
      end
   end

   assign rdata_out = rdata_q;
   assign irq_out = irq_q;
   assign demag_event_out = event_q;

   // checks on arming, sources, flag, interrupt and the register port

   // hall mode keeps the output quiet one cycle later
   a_hall_blocks: assert property (
      @(posedge clock_in) disable iff (srst_in)
      hall_sensor_select |=> !demag_event_out)
      else $error("event produced in hall sensor mode");

   // a pulse not right after a commute leaves nothing armed
   a_one_per_step: assert property (
      @(posedge clock_in) disable iff (srst_in)
      demag_event_out && !$past(commutate_in) |-> !demag_now)
      else $error("second event in one step");

   // every merged event shows as flag and pulse together
   a_flag_on_event: assert property (
      @(posedge clock_in) disable iff (srst_in)
      demag_now |=> demag_flag_q ##0 demag_event_out)
      else $error("event did not set flag");

   // the interrupt never rises past a cleared mask
   a_irq_masked: assert property (
      @(posedge clock_in) disable iff (srst_in)
      irq_out |-> demag_flag_q && $past(demag_irq_mask))
      else $error("interrupt without unmasked flag");

   // capture takes the timer of the event cycle
   a_capture_val: assert property (
      @(posedge clock_in) disable iff (srst_in)
      hw_event && hw_demag_capture_en |=> dtime_q == $past(step_timer_in))
      else $error("timer not captured");

   // a stale time fires at once and is refreshed from the timer
   a_force_fires: assert property (
      @(posedge clock_in) disable iff (srst_in)
      sim_force |=> demag_event_out && dtime_q == $past(step_timer_in))
      else $error("forced event missing");

   // an armed compare hit always reaches the output
   a_sim_match: assert property (
      @(posedge clock_in) disable iff (srst_in)
      live && sim_demag_en && step_timer_in == dtime_q |=> demag_event_out)
      else $error("compare did not fire");

   // nothing fires outside a step
   a_no_arm: assert property (
      @(posedge clock_in) disable iff (srst_in)
      !armed_q && !check_q |-> !demag_now)
      else $error("event while disarmed");

   // pure masking mode: only the simulated sources end the step
   a_hw_source: assert property (
      @(posedge clock_in) disable iff (srst_in)
      !hw_demag_capture_en && sim_demag_en && demag_now |->
      sim_match || sim_force)
      else $error("pin edge ended the masking interval");

   // the first event disarms, so a later source is dropped
   a_disarm_event: assert property (
      @(posedge clock_in) disable iff (srst_in)
      demag_now && !commutate_in |=> !armed_q)
      else $error("still armed after event");

   // a commute arms the step and schedules the stale check
   a_arm_commute: assert property (
      @(posedge clock_in) disable iff (srst_in)
      commutate_in |=> armed_q && check_q)
      else $error("commute did not arm");

   // the stale check looks only in the cycle after a commute
   a_check_once: assert property (
      @(posedge clock_in) disable iff (srst_in)
      check_q |-> $past(commutate_in))
      else $error("stale check outside commute cycle");

   // writing one clears the flag when no event competes
   a_flag_clear: assert property (
      @(posedge clock_in) disable iff (srst_in)
      wr_stat && wdata_in[dmg_pkg::STAT_DEMAG_BIT] && !demag_now |=>
      !demag_flag_q)
      else $error("flag not cleared");

   // the flag is sticky until software writes the status
   a_flag_sticky: assert property (
      @(posedge clock_in) disable iff (srst_in)
      demag_flag_q && !wr_stat |=> demag_flag_q)
      else $error("flag dropped by itself");

   // an event beats a clear in the same cycle
   a_set_wins: assert property (
      @(posedge clock_in) disable iff (srst_in)
      demag_now && wr_stat |=> demag_flag_q)
      else $error("clear beat event");

   // an unmasked standing flag keeps the interrupt up
   a_irq_follow: assert property (
      @(posedge clock_in) disable iff (srst_in)
      demag_flag_q && demag_irq_mask && !wr_stat |=> irq_out)
      else $error("interrupt missing");

   // no flag and no event means no interrupt
   a_irq_drop: assert property (
      @(posedge clock_in) disable iff (srst_in)
      !demag_flag_q && !demag_now |=> !irq_out)
      else $error("interrupt without flag");

   // a cleared mask silences the interrupt line
   a_mask_gates: assert property (
      @(posedge clock_in) disable iff (srst_in)
      !demag_irq_mask |=> !irq_out)
      else $error("interrupt while masked");

   // demag time only moves by write, capture or forced refresh
   a_dtime_hold: assert property (
      @(posedge clock_in) disable iff (srst_in)
      !hw_demag_capture_en && !sim_force && !wr_dtime |=> $stable(dtime_q))
      else $error("demag time changed unasked");

   // read data stand only after a read strobe
   a_rd_idle: assert property (
      @(posedge clock_in) disable iff (srst_in)
      !rd_in |=> rdata_out == 8'h00)
      else $error("read data without strobe");

   // status reads show the flag of the strobe cycle
   a_rd_status: assert property (
      @(posedge clock_in) disable iff (srst_in)
      rd_in && addr_in == dmg_pkg::ADDR_STATUS |=>
      rdata_out == {7'h00, $past(demag_flag_q)})
      else $error("status read wrong");

   // the output pulse always follows an internal event
   a_event_pulse: assert property (
      @(posedge clock_in) disable iff (srst_in)
      demag_event_out |-> $past(demag_now))
      else $error("pulse without event");

   // a filter hit needs a qualified sample inside a live step
   a_hw_qualified: assert property (
      @(posedge clock_in) disable iff (srst_in)
      hw_hit |-> qual && live)
      else $error("hit without qualified sample");

   // hall mode silences every source, not only the output
   a_hall_quiet: assert property (
      @(posedge clock_in) disable iff (srst_in)
      hall_sensor_select |-> !sim_force && !sim_match && !hw_hit)
      else $error("source active in hall mode");

   // control writes land whole in the next cycle
   a_ctrl_write: assert property (
      @(posedge clock_in) disable iff (srst_in)
      wr_ctrl |=> ctrl_q == $past(wdata_in))
      else $error("control write lost");

   // a plain demag time write lands when nothing overrides it
   a_dtime_write: assert property (
      @(posedge clock_in) disable iff (srst_in)
      wr_dtime && !sim_force && !hw_event |=> dtime_q == $past(wdata_in))
      else $error("demag time write lost");

   // unmapped addresses read as zero
   a_rd_unmapped: assert property (
      @(posedge clock_in) disable iff (srst_in)
      rd_in && addr_in > dmg_pkg::ADDR_TIMER |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");

endmodule : dmg_event_gen

// ===== tb/dmg_sense_model.sv
// dmg_sense_model: sense comparator on the free winding; its output steps
// to the end-of-free-wheel level a set number of cycles after commutation.
// assumes: bench drives commutation, delay and level on the same clock.
`timescale 1ns/1ps
module dmg_sense_model (
   // clock and reset
   input wire logic clock_in,
   input wire logic srst_in,
   // step control
   input wire logic commutate_in,
   input wire logic [7:0] delay_in,
   input wire logic level_in,
   // comparator pin
   output logic sense_out
);
   logic [7:0] cnt_q;
   logic [7:0] dly_q;
   logic lvl_q;
   // saturating count since commutation; delay and level are latched
   // with it so the pin cannot glitch before the step really starts
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         cnt_q <= 8'hff;
         dly_q <= 8'hff;
         lvl_q <= 1'b0;
      end else if (commutate_in) begin
         cnt_q <= 8'h00;
         dly_q <= delay_in;
         lvl_q <= level_in;
      end else if (cnt_q != 8'hff) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
   // delay ff never ends free-wheel, so no edge once the step has begun
   assign sense_out = (cnt_q > dly_q) ? lvl_q : !lvl_q;
endmodule : dmg_sense_model

// ===== tb/tb.sv
// tb: self-checking bench for the demagnetization event generator.
// assumes: the bench plays software and the step timer; model plays pin.
`timescale 1ns/1ps
module tb;
   logic clock_in, srst_in, wr_in, rd_in, commutate_in, sense, lvl;
   logic demag_event_out, irq_out;
   logic [3:0] addr_in;
   logic [7:0] wdata_in, rdata_out, step_timer_in, dly, d, t, t_evt;
   int failures, n_compared, n_evt, cyc;
   // register rows: address, write value, read-back value
   logic [3:0] ra [5] = '{dmg_pkg::ADDR_CTRL, dmg_pkg::ADDR_MASK,
      dmg_pkg::ADDR_DTIME, 4'h9, dmg_pkg::ADDR_STATUS};
   logic [7:0] rw [5] = '{8'h7b, 8'h01, 8'h5a, 8'ha5, 8'h01};
   logic [7:0] rx [5] = '{8'h7b, 8'h01, 8'h5a, 8'h00, 8'h00};

   dmg_event_gen dmg_event_gen_inst (.clock_in(clock_in),
      .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .rotor_sense_input_in(sense), .commutate_in(commutate_in),
      .step_timer_in(step_timer_in), .demag_event_out(demag_event_out),
      .irq_out(irq_out));
   dmg_sense_model dmg_sense_model_inst (.clock_in(clock_in),
      .srst_in(srst_in), .commutate_in(commutate_in), .delay_in(dly),
      .level_in(lvl), .sense_out(sense));

   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   // free-running step timer, event watch and hang guard
   always @(posedge clock_in) begin
      step_timer_in <= srst_in ? 8'h00 : step_timer_in + 8'h01;
      cyc++;
      // a commute opens a new step, so the event count restarts there
      if (commutate_in === 1'b1) begin
         n_evt = 0;
      end else if (demag_event_out === 1'b1) begin
         n_evt++;
         t_evt = step_timer_in;
      end
      if (cyc == 5000) begin
         failures++;
         finish_test();
      end
   end

   task chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task chk_rng(input logic [7:0] v, input logic [7:0] lo, hi);
      chk({7'h00, (v >= lo) && (v <= hi)}, 8'h01);
   endtask : chk_rng
   task wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      @(posedge clock_in);
      v = rdata_out;
   endtask : rd
   task commute(input logic [7:0] dv, input logic lv);
      @(posedge clock_in);
      commutate_in <= 1'b1;
      dly <= dv;
      lvl <= lv;
      @(posedge clock_in);
      commutate_in <= 1'b0;
   endtask : commute
   task finish_test;
      if (failures == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test

   initial begin
      {srst_in, wr_in, rd_in, commutate_in, lvl} <= 5'b10000;
      {addr_in, wdata_in, dly} <= {4'h0, 8'h00, 8'hff};
      repeat (10) @(posedge clock_in);
      srst_in <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         wr(ra[i], rw[i]);
         rd(ra[i], d);
         chk(d, rx[i]);
      end
      // second reset in mid-run restores defaults
      srst_in <= 1'b1;
      repeat (10) @(posedge clock_in);
      srst_in <= 1'b0;
      rd(dmg_pkg::ADDR_CTRL, d);
      chk(d, dmg_pkg::CTRL_RST);
      chk({6'h00, irq_out, demag_event_out}, 8'h00);
      rd(dmg_pkg::ADDR_DTIME, d);
      chk(d, dmg_pkg::DTIME_RST);
      // simulated only; early pin edge must be ignored
      wr(dmg_pkg::ADDR_MASK, 8'h01);
      wr(dmg_pkg::ADDR_CTRL, 8'h02);
      t = step_timer_in + 8'h28;
      wr(dmg_pkg::ADDR_DTIME, t);
      commute(8'h05, 1'b0);
      repeat (60) @(posedge clock_in);
      chk(n_evt[7:0], 8'h01);
      chk_rng(t_evt - t, 8'h00, 8'h03);
      rd(dmg_pkg::ADDR_STATUS, d);
      chk(d, 8'h01);
      chk({7'h00, irq_out}, 8'h01);
      wr(dmg_pkg::ADDR_STATUS, 8'h01);
      repeat (3) @(posedge clock_in);
      chk({7'h00, irq_out}, 8'h00);
      // stale time forces an event at once, masked interrupt
      wr(dmg_pkg::ADDR_MASK, 8'h00);
      t = step_timer_in;
      wr(dmg_pkg::ADDR_DTIME, t);
      commute(8'hff, 1'b1);
      repeat (10) @(posedge clock_in);
      chk(n_evt[7:0], 8'h01);
      rd(dmg_pkg::ADDR_DTIME, d);
      chk_rng(t_evt - d, 8'h00, 8'h03);
      chk_rng(d - t, 8'h01, 8'h10);
      chk({7'h00, irq_out}, 8'h00);
      wr(dmg_pkg::ADDR_STATUS, 8'h01);
      // both sources, pin edge first, seven filter samples
      wr(dmg_pkg::ADDR_CTRL, 8'h6b);
      // sim time well after the pin edge yet short of the timer wrap
      wr(dmg_pkg::ADDR_DTIME, step_timer_in + 8'h60);
      t = step_timer_in;
      commute(8'h0a, 1'b1);
      repeat (220) @(posedge clock_in);
      chk(n_evt[7:0], 8'h01);
      chk_rng(t_evt - t, 8'h14, 8'h20);
      rd(dmg_pkg::ADDR_DTIME, d);
      chk_rng(t_evt - d, 8'h00, 8'h03);
      // hall mode blocks even a forced event
      wr(dmg_pkg::ADDR_STATUS, 8'h01);
      wr(dmg_pkg::ADDR_CTRL, 8'h06);
      wr(dmg_pkg::ADDR_DTIME, step_timer_in);
      commute(8'hff, 1'b1);
      repeat (20) @(posedge clock_in);
      chk(n_evt[7:0], 8'h00);
      rd(dmg_pkg::ADDR_STATUS, d);
      chk(d, 8'h00);
      finish_test();
   end
endmodule : tb
